/* File: ascp_pkg.sv */
package ascp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ASCP_CLK_NS      = 20;
  localparam int ASCP_WAKE_NS     = 5000;
  localparam int ASCP_WAKE_CYC    = (ASCP_WAKE_NS + ASCP_CLK_NS - 1) / ASCP_CLK_NS;
  localparam int ASCP_HALF_CYC    = 8;
  localparam int ASCP_GAP_CYC     = 16;

  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int ASCP_FRAME_CLKS  = 16;
  localparam int ASCP_CTRL_BITS   = 8;
  localparam int ASCP_SAMPLE_RISE = 2;
  localparam int ASCP_LEAD_ZEROS  = 4;
  localparam int ASCP_RES_W       = 12;
  localparam int ASCP_NUM_CH      = 8;

  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int ASCP_CH_LSB      = 3;
  localparam int ASCP_CH_W        = 3;
  localparam int ASCP_PM_LSB      = 0;
  localparam logic [7:0] ASCP_CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    ASCP_PM_NORMAL   = 2'b00,
    ASCP_PM_SHUTDOWN = 2'b01,
    ASCP_PM_AUTO_SD  = 2'b10,
    ASCP_PM_AUTO_SB  = 2'b11
  } ascp_pm_t;

  typedef enum logic [1:0] {
    ASCP_DS_IDLE  = 2'b00,
    ASCP_DS_TRACK = 2'b01,
    ASCP_DS_HOLD  = 2'b10
  } ascp_dev_state_t;

  typedef enum logic [2:0] {
    ASCP_HS_IDLE  = 3'b000,
    ASCP_HS_LEAD  = 3'b001,
    ASCP_HS_LOW   = 3'b010,
    ASCP_HS_HIGH  = 3'b011,
    ASCP_HS_GAP   = 3'b100,
    ASCP_HS_TAIL  = 3'b101,
    ASCP_HS_RECOV = 3'b110
  } ascp_host_state_t;

endpackage

/* File: ascp_if.sv */
`timescale 1ns/1ps
interface ascp_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;

  modport device (
    input  cs_n,
    input  sclk,
    input  din,
    output dout,
    output dout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input  dout
  );
endinterface

/* File: ascp_device.sv */
// Contract
// - serial clock drives conversion and transfers
// - chip select fall starts frame, tracking
// - auto shutdown wakes on first falling edge
// - second rising edge holds sample, starts conversion
// - acquisition spans first one and half periods
// - conversion ends fourteen periods later, on sixteenth rise
// - chip select rise releases data output
// - chip select held low restarts next frame
// - converts channel chosen by previous control word
// - control word loads on first eight rises
// - every frame overwrites the control word
// - a frame holds sixteen serial clock periods
// - first falling edge shifts first leading zero
// - rising-first host may miss first zero
// - output changes on falling, host samples rising
// - host may split frame into two bytes
// - host idles clock high, phase one
// - framed host sends one word per frame
// - two power bits select operating mode
// - auto modes power down on sixteenth rise
// - new mode immediate; shutdown exit at sixteenth rise
`timescale 1ns/1ps
module ascp_device #(
  parameter int NUM_CH = ascp_pkg::ASCP_NUM_CH,
  parameter int RES_W  = ascp_pkg::ASCP_RES_W
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // serial link
  ascp_if.device                       link,
  // converter inputs
  input  wire logic [NUM_CH*RES_W-1:0] analog_codes,
  // status
  output logic                         tracking_q,
  output logic                         converting_q,
  output logic                         powered_q,
  output logic [7:0]                   ctrl_word_q,
  // results
  output logic [11:0]                  result_q,
  output logic [2:0]                   result_ch_q,
  output logic                         result_valid_q
);
  import ascp_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (NUM_CH < 1 || NUM_CH > 8 || RES_W < 1 || RES_W > ASCP_RES_W) begin : g_bad_param
      $error("ascp_device: NUM_CH must be 1..8 and RES_W 1..12");
    end
  endgenerate

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [11:0] pick_code(input logic [NUM_CH*RES_W-1:0] codes,
                                             input logic [2:0]              ch);
    logic [11:0] r;
    r = 12'h000;
    if (int'(ch) < NUM_CH) begin
      r = 12'(codes[int'(ch)*RES_W +: RES_W]);
    end
    return r;
  endfunction

  function automatic logic out_bit(input logic [15:0] w, input logic [4:0] k);
    logic b;
    b = 1'b0;
    if (k != 5'h00) begin
      b = w[4'(5'h0F - k)];
    end
    return b;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic cs_s1, cs_s2, cs_s3;
  logic ck_s1, ck_s2, ck_s3;
  logic di_s1, di_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ck_s1 <= 1'b1;
      ck_s2 <= 1'b1;
      ck_s3 <= 1'b1;
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
    end else begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ck_s1 <= link.sclk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      di_s1 <= link.din;
      di_s2 <= di_s1;
    end
  end

  // ----------------------------------------
  // edge decode
  // ----------------------------------------
  ascp_dev_state_t state_q;
  logic [4:0]      rise_cnt_q;
  logic            cs_fall;
  logic            cs_rise;
  logic            frame_on;
  logic            sck_rise;
  logic            sck_fall;
  logic            samp_rise;
  logic            ctrl_rise;
  logic            ctrl_done;
  logic            last_rise;
  ascp_pm_t        pm_cur;
  ascp_pm_t        pm_new;
  logic [7:0]      ctrl_new;
  logic [7:0]      ctrl_sh_q;

  assign cs_fall   = cs_s3 & ~cs_s2;
  assign cs_rise   = ~cs_s3 & cs_s2;
  // clock edges count only inside a frame, never on a select edge
  assign frame_on  = (state_q != ASCP_DS_IDLE) & ~cs_fall & ~cs_rise;
  assign sck_rise  = frame_on & ~ck_s3 & ck_s2;
  assign sck_fall  = frame_on & ck_s3 & ~ck_s2;
  assign samp_rise = sck_rise & (rise_cnt_q == 5'(ASCP_SAMPLE_RISE - 1));
  assign ctrl_rise = sck_rise & (rise_cnt_q < 5'(ASCP_CTRL_BITS));
  assign ctrl_done = sck_rise & (rise_cnt_q == 5'(ASCP_CTRL_BITS - 1));
  assign last_rise = sck_rise & (rise_cnt_q == 5'(ASCP_FRAME_CLKS - 1));
  assign ctrl_new  = {ctrl_sh_q[6:0], di_s2};
  assign pm_cur    = ascp_pm_t'(ctrl_word_q[ASCP_PM_LSB +: 2]);
  assign pm_new    = ascp_pm_t'(ctrl_new[ASCP_PM_LSB +: 2]);

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ASCP_DS_IDLE;
      rise_cnt_q <= 5'h00;
      tracking_q <= 1'b0;
    end else if (cs_fall) begin
      state_q    <= ASCP_DS_TRACK;
      rise_cnt_q <= 5'h00;
      tracking_q <= 1'b1;
    end else if (cs_rise) begin
      state_q    <= ASCP_DS_IDLE;
      rise_cnt_q <= 5'h00;
      tracking_q <= 1'b0;
    end else if (last_rise) begin
      // select still low: next frame starts with no new edge
      state_q    <= ASCP_DS_TRACK;
      rise_cnt_q <= 5'h00;
      tracking_q <= 1'b1;
    end else if (samp_rise) begin
      state_q    <= ASCP_DS_HOLD;
      rise_cnt_q <= rise_cnt_q + 5'h01;
      tracking_q <= 1'b0;
    end else if (sck_rise) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------
  // control word
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_sh_q   <= ASCP_CTRL_RST;
      ctrl_word_q <= ASCP_CTRL_RST;
    end else begin
      if (ctrl_rise) begin
        ctrl_sh_q <= ctrl_new;
      end
      // written every frame, reads included
      if (ctrl_done) begin
        ctrl_word_q <= ctrl_new;
      end
    end
  end

  // ----------------------------------------
  // sample and conversion
  // ----------------------------------------
  logic [15:0] out_word_q;
  logic [11:0] sample_q;
  logic [2:0]  conv_ch_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_word_q     <= 16'h0000;
      sample_q       <= 12'h000;
      conv_ch_q      <= 3'h0;
      converting_q   <= 1'b0;
      result_q       <= 12'h000;
      result_ch_q    <= 3'h0;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= 1'b0;
      if (cs_fall) begin
        out_word_q <= 16'h0000;
      end else if (cs_rise) begin
        // frame cut short: no result
        converting_q <= 1'b0;
      end else if (samp_rise) begin
        // channel still from the word of the previous frame
        sample_q     <= pick_code(analog_codes, ctrl_word_q[ASCP_CH_LSB +: ASCP_CH_W]);
        conv_ch_q    <= ctrl_word_q[ASCP_CH_LSB +: ASCP_CH_W];
        out_word_q   <= {4'h0, pick_code(analog_codes,
                                         ctrl_word_q[ASCP_CH_LSB +: ASCP_CH_W])};
        converting_q <= 1'b1;
      end else if (last_rise) begin
        // last half period only carries the final output bit
        result_q       <= sample_q;
        result_ch_q    <= conv_ch_q;
        result_valid_q <= 1'b1;
        converting_q   <= 1'b0;
        out_word_q     <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // power management
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powered_q <= 1'b1;
    end else if (ctrl_done && pm_new == ASCP_PM_SHUTDOWN) begin
      powered_q <= 1'b0;
    end else if (last_rise) begin
      if (pm_cur == ASCP_PM_NORMAL) begin
        powered_q <= 1'b1;
      end else if (pm_cur[1]) begin
        powered_q <= 1'b0;
      end
    end else if (sck_fall && rise_cnt_q == 5'h00 && pm_cur[1]) begin
      powered_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  logic dout_q;
  logic dout_oe_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (cs_fall) begin
      // zero already there for a rising-first host, if it is fast enough
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b1;
    end else if (cs_rise) begin
      dout_oe_q <= 1'b0;
    end else if (sck_fall) begin
      dout_q <= out_bit(out_word_q, rise_cnt_q);
    end
  end

  assign link.dout    = dout_q;
  assign link.dout_oe = dout_oe_q;

endmodule

/* File: ascp_host.sv */
`timescale 1ns/1ps
module ascp_host #(
  parameter int HALF_CYC = ascp_pkg::ASCP_HALF_CYC,
  parameter int GAP_CYC  = ascp_pkg::ASCP_GAP_CYC,
  parameter int WAKE_CYC = ascp_pkg::ASCP_WAKE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // serial link
  ascp_if.host             link,
  // request
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  input  wire logic        split_bytes,
  input  wire logic        wake_stretch,
  // answer
  output logic             busy_q,
  output logic             done_q,
  output logic [15:0]      rdata_q
);
  import ascp_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (HALF_CYC < 4 || HALF_CYC > 65535 || GAP_CYC < 1 || GAP_CYC > 65535
        || WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_param
      $error("ascp_host: HALF_CYC >= 4, counts below 65536");
    end
  endgenerate

  function automatic logic cmd_bit(input logic [7:0] c, input logic [4:0] k);
    logic b;
    b = 1'b0;
    if (k < 5'(ASCP_CTRL_BITS)) begin
      b = c[3'(5'h07 - k)];
    end
    return b;
  endfunction

  // ----------------------------------------
  // data input synchroniser
  // ----------------------------------------
  logic do_s1, do_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      do_s1 <= 1'b0;
      do_s2 <= 1'b0;
    end else begin
      do_s1 <= link.dout;
      do_s2 <= do_s1;
    end
  end

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  ascp_host_state_t state_q;
  logic [15:0]      cnt_q;
  logic [4:0]       bit_q;
  logic [7:0]       cmd_q;
  logic             split_q;
  logic             stretch_q;
  logic [15:0]      sh_q;
  logic             cs_n_q;
  logic             sclk_q;
  logic             din_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ASCP_HS_IDLE;
      cnt_q     <= 16'h0000;
      bit_q     <= 5'h00;
      cmd_q     <= 8'h00;
      split_q   <= 1'b0;
      stretch_q <= 1'b0;
      sh_q      <= 16'h0000;
      cs_n_q    <= 1'b1;
      sclk_q    <= 1'b1;
      din_q     <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      rdata_q   <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (state_q != ASCP_HS_IDLE && cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        case (state_q)
          ASCP_HS_IDLE: begin
            if (start) begin
              cmd_q     <= cmd;
              split_q   <= split_bytes;
              stretch_q <= wake_stretch;
              bit_q     <= 5'h00;
              cs_n_q    <= 1'b0;
              busy_q    <= 1'b1;
              cnt_q     <= 16'(HALF_CYC - 1);
              state_q   <= ASCP_HS_LEAD;
            end
          end
          ASCP_HS_LEAD, ASCP_HS_HIGH: begin
            // falling edge launches; command bits valid on every read
            sclk_q  <= 1'b0;
            din_q   <= cmd_bit(cmd_q, bit_q);
            state_q <= ASCP_HS_LOW;
            // first low phase stretched to cover wake-up
            if (stretch_q && bit_q == 5'h00) begin
              cnt_q <= 16'(WAKE_CYC - 1);
            end else begin
              cnt_q <= 16'(HALF_CYC - 1);
            end
          end
          ASCP_HS_LOW: begin
            sclk_q <= 1'b1;
            sh_q   <= {sh_q[14:0], do_s2};
            bit_q  <= bit_q + 5'h01;
            if (bit_q == 5'(ASCP_FRAME_CLKS - 1)) begin
              cnt_q   <= 16'(HALF_CYC - 1);
              state_q <= ASCP_HS_TAIL;
            end else if (split_q && bit_q == 5'(ASCP_CTRL_BITS - 1)) begin
              // clock parks high between bytes, select stays low
              cnt_q   <= 16'(GAP_CYC - 1);
              state_q <= ASCP_HS_GAP;
            end else begin
              cnt_q   <= 16'(HALF_CYC - 1);
              state_q <= ASCP_HS_HIGH;
            end
          end
          ASCP_HS_GAP: begin
            cnt_q   <= 16'(HALF_CYC - 1);
            state_q <= ASCP_HS_HIGH;
          end
          ASCP_HS_TAIL: begin
            cs_n_q  <= 1'b1;
            din_q   <= 1'b0;
            rdata_q <= sh_q;
            done_q  <= 1'b1;
            cnt_q   <= 16'(HALF_CYC - 1);
            state_q <= ASCP_HS_RECOV;
          end
          ASCP_HS_RECOV: begin
            busy_q  <= 1'b0;
            state_q <= ASCP_HS_IDLE;
          end
          default: begin
            state_q <= ASCP_HS_IDLE;
          end
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din  = din_q;

endmodule

/* File: ascp_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------
// link checker
// ----------------------------------------
module ascp_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic       sclk_q;
  logic [4:0] rise_cnt_q;
  logic       rise;

  assign rise = sclk && !sclk_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // no wrap: the watched host never chains frames, so 16 is the only legal total
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_cnt_q <= 5'h00;
    end else if (cs_n) begin
      rise_cnt_q <= 5'h00;
    end else if (rise && rise_cnt_q != 5'h1F) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:5] dout_oe)
    else $error("data output not enabled after frame start");
  AST_OE_AT_RISE: assert property (rise && !cs_n |-> dout_oe)
    else $error("data output off at a serial clock rise");
  AST_LEAD_ZEROS: assert property (rise && !cs_n && rise_cnt_q < 5'h04 |-> !dout)
    else $error("leading bit not zero");
  AST_DOUT_HOLD: assert property (
    !cs_n && sclk && sclk_q && dout_oe && $past(dout_oe) |-> $stable(dout))
    else $error("data output moved while serial clock high");
  AST_OE_RELEASE: assert property (cs_n [*4] |-> !dout_oe)
    else $error("data output still driven after deselect");
  AST_SCLK_IDLE: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("serial clock not idling high");
  AST_SIXTEEN: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h10)
    else $error("frame without sixteen clock rises");
  AST_HALF_LOW: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  AST_DIN_HOLD: assert property (
    !cs_n && !$past(cs_n) && sclk && sclk_q |-> $stable(din))
    else $error("command bit moved while serial clock high");
  AST_FIRST_FALL: assert property ($fell(cs_n) |-> !rise [*8])
    else $error("first clock edge of frame is a rise");
endmodule

/* File: adc_serial_conversion_port_test.sv */
`timescale 1ns/1ps
module adc_serial_conversion_port_test;
  import ascp_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic        start        = 1'b0;
  logic [7:0]  cmd          = 8'h00;
  logic        split_bytes  = 1'b0;
  logic        wake_stretch = 1'b0;
  logic [95:0] codes        = 96'h0;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  logic        tracking;
  logic        converting;
  logic        powered;
  logic [7:0]  ctrl_word;
  logic [11:0] result;
  logic [2:0]  result_ch;
  logic        res_valid;
  logic [7:0]  prev_ctrl    = 8'h00;
  logic [7:0]  fr_cmd;
  logic [1:0]  pm_seq [8]   = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
  int          seed         = 32'h102E2F02;
  int          mismatches   = 0;
  int          checks_done  = 0;
  int          i;

  always #10 clk = ~clk;

  ascp_if link ();
  ascp_if link2 ();

  ascp_host #(.WAKE_CYC(ASCP_WAKE_CYC)) ascp_host_inst (.clk(clk), .rst(rst), .link(link.host),
    .start(start), .cmd(cmd), .split_bytes(split_bytes), .wake_stretch(wake_stretch),
    .busy_q(busy), .done_q(done), .rdata_q(rdata));
  ascp_device ascp_device_inst (.clk(clk), .rst(rst), .link(link.device), .analog_codes(codes),
    .tracking_q(tracking), .converting_q(converting), .powered_q(powered),
    .ctrl_word_q(ctrl_word), .result_q(result), .result_ch_q(result_ch),
    .result_valid_q(res_valid));
  // second device faces the bench, which holds select low across frames
  ascp_device ascp_device_inst_b (.clk(clk), .rst(rst), .link(link2.device),
    .analog_codes(codes), .tracking_q(), .converting_q(), .powered_q(), .ctrl_word_q(),
    .result_q(), .result_ch_q(), .result_valid_q());
  ascp_asserts ascp_asserts_inst (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
    .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // one host frame against the model
  // ----------------------------------------
  task automatic run_frame(input logic [7:0] c, input logic sp);
    int          ch;
    int          n;
    int          rises;
    int          conv_at;
    int          low0;
    logic        sq;
    logic        live;
    logic [15:0] exp_word;
    ch = int'(prev_ctrl[ASCP_CH_LSB +: ASCP_CH_W]);
    exp_word = {4'h0, codes[ch*ASCP_RES_W +: ASCP_RES_W]};
    live = (prev_ctrl[1:0] != ASCP_PM_SHUTDOWN);
    rises = 0;
    conv_at = -1;
    low0 = 0;
    sq = 1'b1;
    cmd = c;
    split_bytes = sp;
    wake_stretch = (prev_ctrl[1:0] == ASCP_PM_AUTO_SD);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      if (link.sclk === 1'b1 && sq === 1'b0) begin
        rises++;
        if (rises == 1) begin
          chk(16'(tracking), 16'h0001);
          chk(16'(powered), 16'(prev_ctrl[1:0] != ASCP_PM_SHUTDOWN));
        end
      end
      if (rises == 0 && link.sclk === 1'b0) begin
        low0++;
      end
      sq = link.sclk;
      if (live && converting === 1'b1 && conv_at < 0) begin
        conv_at = rises;
        chk(16'(tracking), 16'h0000);
      end
      if (live && res_valid === 1'b1) begin
        chk(16'(rises), 16'h0010);
      end
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      stop_test();
    end
    if (live) begin
      chk(rdata, exp_word);
      chk(16'(conv_at), 16'h0002);
      chk(16'({result_ch, result}), 16'({ch[2:0], exp_word[11:0]}));
    end
    if (wake_stretch) begin
      chk(16'(low0 >= ASCP_WAKE_CYC), 16'h0001);
    end
    chk(16'(ctrl_word), 16'(c));
    chk(16'(powered), 16'(c[1:0] == ASCP_PM_NORMAL));
    prev_ctrl = c;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      stop_test();
    end
  endtask

  // ----------------------------------------
  // frames chained with select held low
  // ----------------------------------------
  task automatic drive_chain(input int nf);
    logic [7:0]  c;
    logic [7:0]  pend [$];
    logic [15:0] w;
    int          f;
    int          k;
    // reset word selects channel 0 for the first frame
    pend.push_back(8'h00);
    link2.cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (f = 0; f < nf; f++) begin
      c = 8'($random(seed));
      c[1:0] = 2'b00;
      w = 16'h0000;
      for (k = 0; k < 16; k++) begin
        link2.sclk = 1'b0;
        // trailing command bits are noise the device must ignore
        link2.din = (k < 8) ? c[7-k] : 1'($random(seed));
        repeat (4) @(negedge clk);
        link2.sclk = 1'b1;
        w = {w[14:0], link2.dout};
        repeat (4) @(negedge clk);
      end
      chk(w, {4'h0, codes[int'(pend[0][5:3])*ASCP_RES_W +: ASCP_RES_W]});
      void'(pend.pop_front());
      pend.push_back(c);
    end
    link2.cs_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(16'(link2.dout_oe), 16'h0000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b1;
    link2.din = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    for (i = 0; i < 16; i++) begin
      codes = {$random(seed), $random(seed), $random(seed)};
      fr_cmd = 8'($random(seed));
      fr_cmd[1:0] = pm_seq[i % 8];
      run_frame(fr_cmd, 1'((i / 2) % 2));
    end
    drive_chain(3);
    stop_test();
  end
endmodule
